// ==== common/fcs_regs.vh ====
// Constants for the configuration sequencer: timings, field codes, stream layout.
// Assumes a 100 MHz system clock; no software-visible registers exist.
`ifndef FCS_REGS_VH
`define FCS_REGS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FCS_CLK_MHZ        100
`define FCS_POR_US         16000
`define FCS_MASTER_MULT    4
`define FCS_INIT_DLY_US    50
`define FCS_MODE_WAIT      24'h000002
`define FCS_ARM_INIT       2'h3
`define FCS_CONFIG_CLOCK_SLOW_HALF 8'h40
`define FCS_RATE_MULT      8'h08

// ----------------------------------------------------------------
// Stream layout
// ----------------------------------------------------------------
`define FCS_PREAMBLE       4'h2
`define FCS_LEN_BITS       5'h18
`define FCS_CHK_BITS       3'h4
`define FCS_EOF_PATTERN    4'h6
`define FCS_FRAME_BITS     12'h07e
`define FCS_FRAMES         12'h1ac
`define FCS_RATE_BIT_POS   12'h003

// ----------------------------------------------------------------
// Checksums
// ----------------------------------------------------------------
`define FCS_CRC_POLY       16'h1021
`define FCS_CRC_INIT       16'h0000
`define FCS_RB_SUM_BITS    4'hb

`endif

// ==== hw/fcs_sequencer.v ====
// Power-up configuration sequencer: memory clear, init handshake, header
// parse, frame loading with error check, daisy gating and readback checksum.
// Assumes serial data on data_in, pins arriving asynchronous to clk.
`include "fcs_regs.vh"

module fcs_sequencer #(
  parameter POR_CYCLES  = `FCS_POR_US * `FCS_CLK_MHZ,
  parameter INIT_CYCLES = `FCS_INIT_DLY_US * `FCS_CLK_MHZ
) (
  // Clock and reset
  input  wire        clk,
  input  wire        nrst,
  // Control pins
  input  wire        reprogram_n,
  input  wire [2:0]  mode_pins,
  input  wire        crc_check_en,
  // Open-drain init status
  input  wire        init_status_n_in,
  output reg         init_status_n_out,
  output reg         init_status_n_oe_n,
  // Configuration link
  input  wire        config_clock_in,
  output reg         config_clock_out,
  input  wire        data_in,
  output reg         daisy_data_out,
  // Status pins
  output reg         high_during_config,
  output reg         low_during_config,
  output reg         config_done,
  output reg         config_error,
  // Readback
  input  wire        readback_req,
  input  wire        readback_bit,
  input  wire        readback_last,
  output reg         readback_out
);

  localparam [3:0] S_CLEAR = 4'h0, S_LASTCLR = 4'h1, S_WAITINIT = 4'h2, S_INITDLY = 4'h3,
                   S_HDR   = 4'h4, S_LEN     = 4'h5, S_GAP      = 4'h6, S_FRAME   = 4'h7,
                   S_CHK   = 4'h8, S_TAIL    = 4'h9, S_DONE     = 4'ha, S_ERR     = 4'hb;
  localparam [1:0] RB_IDLE = 2'h0, RB_DATA = 2'h1, RB_SUM = 2'h2;

  function [15:0] crc_step;
    input [15:0] c;
    input        b;
    begin
      crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `FCS_CRC_POLY : 16'h0000);
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0] prog_s_q, init_s_q, cci_s_q, din_s_q, rbr_s_q;
  reg [2:0] m_s1_q, m_s2_q;
  reg       cci_d1_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prog_s_q <= 2'h0;
      init_s_q <= 2'h0;
      cci_s_q  <= 2'h0;
      din_s_q  <= 2'h3;
      rbr_s_q  <= 2'h0;
      m_s1_q   <= 3'h7;
      m_s2_q   <= 3'h7;
      cci_d1_q <= 1'b0;
    end else begin
      prog_s_q <= {prog_s_q[0], reprogram_n};
      init_s_q <= {init_s_q[0], init_status_n_in};
      cci_s_q  <= {cci_s_q[0], config_clock_in};
      din_s_q  <= {din_s_q[0], data_in};
      rbr_s_q  <= {rbr_s_q[0], readback_req};
      m_s1_q   <= mode_pins;
      m_s2_q   <= m_s1_q;
      cci_d1_q <= cci_s_q[1];
    end
  end
  wire prog_n  = prog_s_q[1];
  wire init_hi = init_s_q[1];
  wire din     = din_s_q[1];

  // ----------------------------------------------------------------
  // State and counters
  // ----------------------------------------------------------------
  reg [3:0]  st_q;
  reg [11:0] fa_q, bit_q, frame_q;
  reg [23:0] dly_q, len_q, ccnt_q, por_q;
  reg [1:0]  arm_q;
  reg        master_q, cfg_master_q, rate_fast_q;
  reg [3:0]  hdr_q, chk_q;
  reg [15:0] crc_q, rb_crc_q;
  reg [7:0]  div_q;
  reg [1:0]  rb_q;
  reg [3:0]  rb_cnt_q;

  wire por_busy = (arm_q != 2'h0) || (por_q != 24'h000000);
  wire pass_end = (fa_q == `FCS_FRAMES - 12'h001);
  wire [31:0] por_long = POR_CYCLES * `FCS_MASTER_MULT;

  // Master configuration clock; the edge pulse stands in for the pin edge
  wire [7:0] half   = rate_fast_q ? (`FCS_CONFIG_CLOCK_SLOW_HALF / `FCS_RATE_MULT)
                                  : `FCS_CONFIG_CLOCK_SLOW_HALF;
  wire       loading = (st_q >= S_HDR) && (st_q <= S_TAIL);
  wire       m_edge  = cfg_master_q && loading && !config_clock_out && (div_q == 8'h00);
  wire       s_edge  = !cfg_master_q && cci_s_q[1] && !cci_d1_q;
  wire       cc_edge = m_edge || s_edge;
  wire [3:0] chk_nx  = {chk_q[2:0], din};
  wire [3:0] chk_exp = crc_check_en ? crc_q[15:12] : `FCS_EOF_PATTERN;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q         <= S_CLEAR;
      fa_q         <= 12'h000;
      bit_q        <= 12'h000;
      frame_q      <= 12'h000;
      dly_q        <= 24'h000000;
      len_q        <= 24'h000000;
      ccnt_q       <= 24'h000000;
      por_q        <= 24'h000000;
      arm_q        <= `FCS_ARM_INIT;
      master_q     <= 1'b0;
      cfg_master_q <= 1'b0;
      rate_fast_q  <= 1'b0;
      hdr_q        <= 4'hf;
      chk_q        <= 4'hf;
      crc_q        <= `FCS_CRC_INIT;
      div_q        <= 8'h00;
      config_clock_out <= 1'b0;
    end else begin
      // Power-on delay armed once the mode pin has settled in the synchroniser
      if (arm_q != 2'h0) begin
        arm_q <= arm_q - 2'h1;
        if (arm_q == 2'h1)
          por_q <= m_s2_q[0] ? POR_CYCLES[23:0]
                             : por_long[23:0];
      end else if (por_q != 24'h000000) begin
        por_q <= por_q - 24'h000001;
      end

      // Master clock divider, runs only while loading
      if (cfg_master_q && loading) begin
        if (div_q == 8'h00) begin
          config_clock_out <= !config_clock_out;
          div_q            <= half - 8'h01;
        end else begin
          div_q <= div_q - 8'h01;
        end
      end else begin
        config_clock_out <= 1'b0;
        div_q            <= 8'h00;
      end

      if (cc_edge && loading)
        ccnt_q <= ccnt_q + 24'h000001;

      if (!prog_n) begin
        // Pulsed reprogram never reloads por_q, so no power-on delay follows
        st_q <= S_CLEAR;
        fa_q <= 12'h000;
      end else begin
        case (st_q)
          S_CLEAR: begin
            fa_q <= pass_end ? 12'h000 : fa_q + 12'h001;
            if (pass_end && !por_busy)
              st_q <= S_LASTCLR;
          end
          S_LASTCLR: begin
            fa_q <= pass_end ? 12'h000 : fa_q + 12'h001;
            if (pass_end)
              st_q <= S_WAITINIT;
          end
          S_WAITINIT: begin
            if (init_hi) begin
              master_q <= !m_s2_q[0];
              dly_q    <= !m_s2_q[0] ? INIT_CYCLES[23:0] + `FCS_MODE_WAIT
                                     : `FCS_MODE_WAIT;
              st_q     <= S_INITDLY;
            end
          end
          S_INITDLY: begin
            if (!init_hi) begin
              st_q <= S_WAITINIT;
            end else if (dly_q == 24'h000001) begin
              cfg_master_q <= !m_s2_q[0];
              rate_fast_q  <= 1'b0;
              ccnt_q       <= 24'h000000;
              hdr_q        <= 4'hf;
              frame_q      <= 12'h000;
              crc_q        <= `FCS_CRC_INIT;
              st_q         <= S_HDR;
            end else begin
              dly_q <= dly_q - 24'h000001;
            end
          end
          S_HDR: if (cc_edge) begin
            hdr_q <= {hdr_q[2:0], din};
            bit_q <= 12'h000;
            if ({hdr_q[2:0], din} == `FCS_PREAMBLE)
              st_q <= S_LEN;
          end
          S_LEN: if (cc_edge) begin
            len_q <= {len_q[22:0], din};
            bit_q <= bit_q + 12'h001;
            if (bit_q == {7'h00, `FCS_LEN_BITS} - 12'h001)
              st_q <= S_GAP;
          end
          S_GAP: if (cc_edge && !din) begin
            bit_q <= 12'h000;
            st_q  <= S_FRAME;
          end
          S_FRAME: if (cc_edge) begin
            crc_q <= crc_step(crc_q, din);
            bit_q <= bit_q + 12'h001;
            if (frame_q == 12'h000 && bit_q == `FCS_RATE_BIT_POS && din)
              rate_fast_q <= 1'b1;
            if (bit_q == `FCS_FRAME_BITS - 12'h001) begin
              bit_q <= 12'h000;
              st_q  <= S_CHK;
            end
          end
          S_CHK: if (cc_edge) begin
            chk_q <= chk_nx;
            bit_q <= bit_q + 12'h001;
            if (bit_q == {9'h000, `FCS_CHK_BITS} - 12'h001) begin
              if (chk_nx != chk_exp)
                st_q <= S_ERR;
              else if (frame_q == `FCS_FRAMES - 12'h001)
                st_q <= S_TAIL;
              else begin
                frame_q <= frame_q + 12'h001;
                st_q    <= S_GAP;
              end
            end
          end
          S_TAIL: if (ccnt_q == len_q)
            st_q <= S_DONE;
          S_DONE: st_q <= S_DONE;
          S_ERR:  st_q <= S_ERR;
          default: st_q <= S_CLEAR;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Status and link outputs
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      init_status_n_out  <= 1'b0;
      init_status_n_oe_n <= 1'b0;
      daisy_data_out     <= 1'b1;
      high_during_config <= 1'b1;
      low_during_config  <= 1'b0;
      config_done        <= 1'b0;
      config_error       <= 1'b0;
    end else begin
      init_status_n_out  <= 1'b0;
      // Drive low while clearing, on reprogram and on a frame error
      init_status_n_oe_n <= !(!prog_n || st_q == S_CLEAR || st_q == S_LASTCLR
                              || st_q == S_ERR);
      high_during_config <= !((st_q == S_DONE) && prog_n);
      low_during_config  <= (st_q == S_DONE) && prog_n;
      config_done        <= (st_q == S_DONE) && prog_n;
      config_error       <= (st_q == S_ERR) && prog_n;
      case (st_q)
        S_HDR, S_LEN, S_TAIL, S_DONE: daisy_data_out <= din;
        default:                      daisy_data_out <= 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Readback with appended checksum
  // ----------------------------------------------------------------
  // Readback uses the slave clock edge only; in master mode s_edge never fires, so readback stalls
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rb_q         <= RB_IDLE;
      rb_cnt_q     <= 4'h0;
      rb_crc_q     <= `FCS_CRC_INIT;
      readback_out <= 1'b1;
    end else if (!prog_n) begin
      rb_q         <= RB_IDLE;
      readback_out <= 1'b1;
    end else begin
      case (rb_q)
        RB_IDLE: begin
          rb_crc_q <= `FCS_CRC_INIT;
          if (st_q == S_DONE && rbr_s_q[1])
            rb_q <= RB_DATA;
        end
        RB_DATA: if (s_edge) begin
          readback_out <= readback_bit;
          rb_crc_q     <= crc_step(rb_crc_q, readback_bit);
          rb_cnt_q     <= 4'h0;
          if (readback_last)
            rb_q <= RB_SUM;
        end
        RB_SUM: if (s_edge) begin
          readback_out <= rb_crc_q[15];
          rb_crc_q     <= {rb_crc_q[14:0], 1'b0};
          rb_cnt_q     <= rb_cnt_q + 4'h1;
          if (rb_cnt_q == `FCS_RB_SUM_BITS - 4'h1)
            rb_q <= RB_IDLE;
        end
        default: rb_q <= RB_IDLE;
      endcase
    end
  end

endmodule

// ==== verif/fcs_seq_asserts.sv ====
// Checker for the configuration sequencer's status and init pin timing.
// Assumes a bind to fcs_sequencer and the same POR_CYCLES value.
`include "fcs_regs.vh"
module fcs_seq_asserts #(parameter POR_CYCLES = 1000) (
  input wire       clk,
  input wire       nrst,
  input wire       reprogram_n,
  input wire [2:0] mode_pins,
  input wire       init_status_n_oe_n,
  input wire       config_error,
  input wire       config_done,
  input wire       high_during_config,
  input wire       low_during_config,
  input wire       readback_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // Cycle counters since reset and since reprogram
  // ----
  int unsigned sr_q;
  int unsigned rp_q;
  logic        md_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sr_q <= 0;
      rp_q <= 0;
    end else begin
      sr_q <= sr_q + 1;
      rp_q <= reprogram_n ? rp_q + 1 : 0;
    end
  end
  // Mode pin is settled only at the first edges after reset
  always_ff @(posedge clk) begin
    md_q <= (sr_q < 2) ? mode_pins[0] : md_q;
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_rp_low;
    !reprogram_n [*5];
  endsequence
  sequence s_err_up;
    !config_error ##1 config_error;
  endsequence
  AST_RPLOW: assert property (s_rp_low |-> !init_status_n_oe_n)
    else $error("init released while reprogram low");
  AST_STATUS: assert property (!config_done |-> high_during_config && !low_during_config)
    else $error("status pins wrong before done");
  AST_ERRINIT: assert property (s_err_up |-> ##[0:2] !init_status_n_oe_n)
    else $error("frame error did not pull init low");
  AST_ERRHOLD: assert property (config_error [*3] |-> !init_status_n_oe_n)
    else $error("init released during error wait");
  AST_ERRLATCH: assert property (config_error && reprogram_n && $past(reprogram_n)
    && $past(reprogram_n, 2) && $past(reprogram_n, 3) |=> config_error)
    else $error("error state left without reprogram");
  AST_NODONE: assert property (config_error |-> !config_done)
    else $error("done raised after frame error");
  AST_RELPASS: assert property ($rose(init_status_n_oe_n) |-> rp_q >= `FCS_FRAMES)
    else $error("init released before a full clearing pass");
  AST_POR: assert property ($rose(init_status_n_oe_n) |-> sr_q >= (md_q ? 1 : 4) * POR_CYCLES)
    else $error("init released before power-on delay");
  AST_RBIDLE: assert property (!config_done |-> readback_out)
    else $error("readback output not idle");
endmodule

// ==== verif/fcs_src_model.sv ====
// Serial configuration source on the slave link: header and frames.
// Assumes the bench calls one task at a time; clock stands still between.
`include "fcs_regs.vh"
module fcs_src_model;
  timeunit 1ns;
  timeprecision 100ps;
  logic        config_clock = 1'b0;
  logic        dat  = 1'b1;
  logic [15:0] crc  = 16'h0000;
  // ----
  // Bit and field senders
  // ----
  task automatic put(input logic b);
    dat = b;
    #40 config_clock = 1'b1;
    #40 config_clock = 1'b0;
  endtask
  task automatic header(input logic [23:0] len);
    logic [39:0] h;
    #3;
    crc = 16'h0000;
    h = {8'hff, `FCS_PREAMBLE, len, 4'hf};
    for (int i = 39; i >= 0; i--) put(h[i]);
    // No pull-up on the data line: show the inverse, not a held value
    dat = ~dat;
    #40;
  endtask
  task automatic frame(input logic [125:0] d, input logic crc_on, input logic bad);
    logic [3:0] chk;
    put(1'b0);
    for (int i = 125; i >= 0; i--) begin
      put(d[i]);
      crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ d[i]) ? `FCS_CRC_POLY : 16'h0000);
    end
    chk = crc_on ? crc[15:12] : `FCS_EOF_PATTERN;
    for (int i = 3; i >= 0; i--) put(chk[i] ^ bad);
    dat = ~dat;
    #40;
  endtask
endmodule

// ==== verif/fcs_sequencer_bench.sv ====
// Bench for the sequencer: power-on, init hold, frame checks, reprogram,
// master clocking. Assumes the source model and the bound checker.
`include "fcs_regs.vh"
module fcs_sequencer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int POR = 1000;
  localparam int INI = 10;
  localparam int F   = `FCS_FRAMES;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        reprogram_n = 1'b1;
  logic [2:0]  mode_pins = 3'b111;
  logic        crc_check_en = 1'b1;
  logic        ext_n = 1'b0;
  logic        init_status_n_out, init_status_n_oe_n, config_clock_out, daisy_data_out;
  logic        high_during_config, low_during_config, config_done, config_error;
  logic        readback_out, init_w;
  int          n_errors = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          t_q = 0;
  logic        oe_q = 1'b0;
  logic [31:0] rel_q[$];
  logic [31:0] lim;
  logic [31:0] rs = 32'h00007fa4;
  always #5 clk = ~clk;
  fcs_src_model u_src ();
  assign init_w = (init_status_n_oe_n | init_status_n_out) & ext_n;
  fcs_sequencer #(.POR_CYCLES(POR), .INIT_CYCLES(INI)) u_dut (
    .clk(clk), .nrst(nrst), .reprogram_n(reprogram_n), .mode_pins(mode_pins),
    .crc_check_en(crc_check_en), .init_status_n_in(init_w),
    .init_status_n_out(init_status_n_out), .init_status_n_oe_n(init_status_n_oe_n),
    .config_clock_in(u_src.config_clock), .config_clock_out(config_clock_out),
    .data_in(u_src.dat), .daisy_data_out(daisy_data_out),
    .high_during_config(high_during_config), .low_during_config(low_during_config),
    .config_done(config_done), .config_error(config_error), .readback_req(1'b0),
    .readback_bit(1'b0), .readback_last(1'b0), .readback_out(readback_out));
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic logic [125:0] rnd();
    logic [127:0] r;
    r = {xs(), xs(), xs(), xs()};
    return r[125:0];
  endfunction
  function automatic logic [31:0] win(input int lo, input int hi);
    return {lo[15:0], hi[15:0]};
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic settle(input int n);
    cycles(n);
    @(negedge clk);
  endtask
  task automatic wait_rel();
    for (int i = 0; i < 6000 && init_status_n_oe_n !== 1'b1; i++) @(posedge clk);
    cycles(2);
  endtask
  // ----
  // Release-time watcher and timeout
  // ----
  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 40000) begin
      n_errors++;
      end_sim();
    end
    t_q <= (!nrst || !reprogram_n) ? 0 : t_q + 1;
    oe_q <= init_status_n_oe_n;
    if (nrst && init_status_n_oe_n === 1'b1 && !oe_q) begin
      if (rel_q.size() == 0)
        check("unexpected_release", 1, 0);
      else begin
        lim = rel_q.pop_front();
        check("release_time", t_q >= lim[31:16] && t_q <= lim[15:0], 1);
      end
    end
  end
  // ----
  // Main sequence
  // ----
  initial begin
    int t;
    cycles(10);
    nrst <= 1'b1;
    rel_q.push_back(win(POR + F, POR + 2 * F + 20));
    settle(2);
    check("oe_after_reset", init_status_n_oe_n, 0);
    check("status", {high_during_config, low_during_config, config_done, config_error}, 4'h8);
    wait_rel();
    settle(20);
    check("held_done", config_done, 0);
    check("held_release", init_status_n_oe_n, 1);
    @(posedge clk);
    ext_n <= 1'b1;
    cycles(INI + 10);
    u_src.header(24'hffffff);
    u_src.frame(rnd(), 1'b1, 1'b0);
    fork
      u_src.frame(rnd(), 1'b1, 1'b0);
      begin
        settle(500);
        check("daisy_in_frame", daisy_data_out, 1);
      end
    join
    settle(20);
    check("crc_frames_ok", config_error, 0);
    u_src.frame(rnd(), 1'b1, 1'b1);
    settle(20);
    check("bad_frame", {config_error, init_status_n_oe_n}, 2'b10);
    @(posedge clk);
    reprogram_n <= 1'b0;
    settle(50);
    check("init_low_reprog", init_status_n_oe_n, 0);
    rel_q.push_back(win(2 * F, 2 * F + 20));
    @(posedge clk);
    reprogram_n <= 1'b1;
    crc_check_en <= 1'b0;
    wait_rel();
    settle(0);
    check("error_cleared", config_error, 0);
    cycles(INI + 10);
    u_src.header(24'hffffff);
    u_src.frame(rnd(), 1'b0, 1'b0);
    settle(20);
    check("pattern_ok", config_error, 0);
    u_src.frame(rnd(), 1'b0, 1'b1);
    settle(20);
    check("pattern_bad", config_error, 1);
    @(posedge clk);
    nrst <= 1'b0;
    mode_pins <= 3'b110;
    rel_q.push_back(win(4 * POR + F, 4 * POR + 2 * F + 20));
    cycles(10);
    nrst <= 1'b1;
    wait_rel();
    t = 0;
    while (config_clock_out !== 1'b1 && t < INI + 500) begin
      @(negedge clk);
      t++;
    end
    check("master_wait", t >= INI, 1);
    t = 0;
    while (config_clock_out === 1'b1 && t < 500) begin
      @(negedge clk);
      t++;
    end
    check("slow_half", t, `FCS_CONFIG_CLOCK_SLOW_HALF);
    check("releases_seen", rel_q.size(), 0);
    end_sim();
  end
endmodule
bind fcs_sequencer fcs_seq_asserts #(.POR_CYCLES(POR_CYCLES)) u_chk (
  .clk(clk), .nrst(nrst), .reprogram_n(reprogram_n), .mode_pins(mode_pins),
  .init_status_n_oe_n(init_status_n_oe_n), .config_error(config_error),
  .config_done(config_done), .high_during_config(high_during_config),
  .low_during_config(low_during_config), .readback_out(readback_out));
